// ---- pfl_flash_master.sv ----
/*
 * Flash request master standing for the processor core or the emulator port.
 * Assumes the lock answers with a one-cycle grant or refuse after the taking edge.
 */
`timescale 1ns/10ps
`default_nettype none
module pfl_flash_master (
    // Clock
    input wire logic clk,
    // Request
    output logic req,
    output logic [1:0] op,
    output logic [6:0] page,
    // Answer
    input wire logic grant,
    input wire logic refuse
);
    initial begin
        req = 1'b0;
        op = 2'h0;
        page = 7'h00;
    end
    // Idle fields show the inverse of the last request so stale values cannot pass
    task automatic issue(input logic [1:0] o, input logic [6:0] p, output logic [7:0] ans);
        @(negedge clk);
        req = 1'b1;
        op = o;
        page = p;
        @(negedge clk);
        ans = {6'h00, grant, refuse};
        req = 1'b0;
        op = ~o;
        page = ~p;
    endtask
endmodule // pfl_flash_master
`default_nettype wire

// ---- pfl_lock.sv ----
/*
 * Program security fuse lock: code-protect bit, fuse burn sequencer,
 * sticky security fuses and the gate on emulator and processor flash
 * requests. Assumes the processor presents single-cycle register strobes
 * on clk, that por_n is a power-on reset only and that rst_n is the
 * processor/chip reset. The strap pin is asynchronous.
 * Fuses are sticky flops that only por_n clears; a chip reset keeps them.
 */
`timescale 1ns/10ps
`default_nettype none
module pfl_lock #(
    parameter int BURN_CYCLES = pfl_pkg::BURN_CYCLES
) (
    // Clock and resets
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    // Internal special function register bus
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    // External-space peripheral register bus
    input wire logic xsfr_wr,
    input wire logic xsfr_rd,
    input wire logic [15:0] xsfr_addr,
    // Shared write data and registered read data
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Lock strap pin
    input wire logic strap_pin,
    // Emulator port flash requests
    input wire logic emu_req,
    input wire logic [1:0] emu_op,
    input wire logic [6:0] emu_page,
    output logic emu_grant,
    output logic emu_refuse,
    output logic emulator_port_disable,
    // Processor flash requests
    input wire logic cpu_req,
    input wire logic [1:0] cpu_op,
    input wire logic [6:0] cpu_page,
    output logic cpu_grant,
    output logic cpu_refuse,
    // Protection status to the memory system
    output logic ext_read_block,
    output logic external_data_ram_clear,
    output logic fuse_burn_strobe
);
    typedef struct packed {
        // Strap synchroniser
        logic strap_s1;
        logic strap_s2;
        // Lock and boot sampling
        logic code_protect_bit;
        logic booted;
        logic level1_sampled;
        // Burn sequencer
        logic level1_select;
        logic strap_dropped;
        pfl_pkg::pfl_burn_t burn;
        logic [pfl_pkg::BURN_CNT_W-1:0] burn_cnt;
        // Registered outputs
        logic [7:0] rdata;
        logic emu_grant;
        logic emu_refuse;
        logic emu_disable;
        logic cpu_grant;
        logic cpu_refuse;
        logic read_block;
        logic ram_clear;
        logic burning;
    } pfl_state_t;

    // Kept apart: fuses answer to power-on reset only
    typedef struct packed {
        logic level0_fuse;
        logic level1_fuse;
    } pfl_fuse_t;

    localparam logic [pfl_pkg::BURN_CNT_W-1:0] BURN_LOAD =
        pfl_pkg::BURN_CNT_W'(BURN_CYCLES - 1);

    pfl_state_t state_reg;
    pfl_state_t state_next;
    pfl_fuse_t fuse_reg;
    pfl_fuse_t fuse_next;

    // Gate results
    logic protect_on;
    logic emu_off;
    logic emu_ok;
    logic cpu_ok;
    // Decoded register strobes
    logic fc_wr;
    logic trig_wr;
    logic key_wr;
    logic stat_wr;
    logic fc_rd;
    logic stat_rd;
    logic burn_done;

    always_comb begin
        // One address per register; unmapped addresses match nothing
        fc_wr = sfr_wr && (sfr_addr == pfl_pkg::ADDR_FLASH_CONTROL);
        fc_rd = sfr_rd && (sfr_addr == pfl_pkg::ADDR_FLASH_CONTROL);
        trig_wr = xsfr_wr && (xsfr_addr == pfl_pkg::ADDR_FUSE_BURN_TRIGGER);
        key_wr = xsfr_wr && (xsfr_addr == pfl_pkg::ADDR_FUSE_UNLOCK_KEY);
        stat_wr = xsfr_wr && (xsfr_addr == pfl_pkg::ADDR_PROTECTION_FUSE_STATUS);
        stat_rd = xsfr_rd && (xsfr_addr == pfl_pkg::ADDR_PROTECTION_FUSE_STATUS);
        // The bit only counts once the level 0 fuse is blown
        protect_on = state_reg.code_protect_bit && fuse_reg.level0_fuse;
        // Live fuse covers a burn completed since the last reset
        emu_off = state_reg.level1_sampled || fuse_reg.level1_fuse;
    end

    // Burn ends when the counter loaded at the trigger has run down
    always_comb begin
        burn_done = (state_reg.burn == pfl_pkg::BURN_ACTIVE)
            && (state_reg.burn_cnt == '0);
    end

    // Emulator gate; level 1 shuts the port whatever the operation
    always_comb begin
        emu_ok = 1'b1;
        if (emu_off) begin
            emu_ok = 1'b0;
        end else if (protect_on) begin
            case (emu_op)
                pfl_pkg::OP_READ: begin
                    // No external view of code or data while protected
                    emu_ok = 1'b0;
                end
                pfl_pkg::OP_WRITE: begin
                    if (emu_page == pfl_pkg::PAGE_ZERO) begin
                        emu_ok = 1'b0;
                    end else begin
                        emu_ok = 1'b0;
                    end
                end
                pfl_pkg::OP_PAGE_ERASE: begin
                    if (emu_page == pfl_pkg::PAGE_ZERO) begin
                        emu_ok = 1'b0;
                    end else begin
                        emu_ok = 1'b0;
                    end
                end
                pfl_pkg::OP_BULK_ERASE: begin
                    // The one operation the emulator may still start under level 0
                    emu_ok = 1'b1;
                end
                default: begin
                    emu_ok = 1'b0;
                end
            endcase
        end
    end

    // Processor gate; the bulk erase path belongs to the emulator only
    always_comb begin
        cpu_ok = 1'b1;
        // Page zero is guarded only while level 0 is active
        case (cpu_op)
            pfl_pkg::OP_READ: begin
                // The processor always reads its own code
                cpu_ok = 1'b1;
            end
            pfl_pkg::OP_WRITE: begin
                if (protect_on && cpu_page == pfl_pkg::PAGE_ZERO) begin
                    cpu_ok = 1'b0;
                end
            end
            pfl_pkg::OP_PAGE_ERASE: begin
                if (protect_on && cpu_page == pfl_pkg::PAGE_ZERO) begin
                    cpu_ok = 1'b0;
                end
            end
            pfl_pkg::OP_BULK_ERASE: begin
                // Global erase is started from the emulator side only
                cpu_ok = 1'b0;
            end
            default: cpu_ok = 1'b1;
        endcase
    end

    always_comb begin
        // Hold everything unless a branch below says otherwise
        state_next = state_reg;
        fuse_next = fuse_reg;

        // Strap passes two flops before anything looks at it
        state_next.strap_s1 = strap_pin;
        state_next.strap_s2 = state_reg.strap_s1;

        // Level 1 is taken on the first edge after reset release
        state_next.booted = 1'b1;
        if (!state_reg.booted) begin
            // Held until the next chip reset, whatever the fuse does later
            state_next.level1_sampled = fuse_reg.level1_fuse;
        end

        // Set-only; zero writes leave it alone, reset alone clears it
        if (fc_wr && reg_wdata[pfl_pkg::CODE_PROTECT_POS]) begin
            state_next.code_protect_bit = 1'b1;
        end

        // Fuse burn sequencer
        case (state_reg.burn)
            pfl_pkg::BURN_IDLE: begin
                // Other key values are refused and leave it idle
                if (key_wr && reg_wdata == pfl_pkg::UNLOCK_KEY) begin
                    state_next.burn = pfl_pkg::BURN_UNLOCKED;
                end
            end
            pfl_pkg::BURN_UNLOCKED: begin
                // Waiting for a selection code; other values are ignored
                if (key_wr && reg_wdata != pfl_pkg::UNLOCK_KEY) begin
                    state_next.burn = pfl_pkg::BURN_IDLE;
                end else if (stat_wr && reg_wdata[pfl_pkg::PROGRAM_ENABLE_POS]) begin
                    // Program enable bit is part of both selection codes
                    if (reg_wdata == pfl_pkg::SELECT_LEVEL0) begin
                        state_next.level1_select = 1'b0;
                        state_next.burn = pfl_pkg::BURN_SELECTED;
                    end else if (reg_wdata == pfl_pkg::SELECT_LEVEL1) begin
                        state_next.level1_select = 1'b1;
                        state_next.burn = pfl_pkg::BURN_SELECTED;
                    end
                end
            end
            pfl_pkg::BURN_SELECTED: begin
                // Waiting for the trigger; the selection may still be withdrawn
                if (key_wr && reg_wdata != pfl_pkg::UNLOCK_KEY) begin
                    state_next.burn = pfl_pkg::BURN_IDLE;
                end else if (stat_wr && !reg_wdata[pfl_pkg::PROGRAM_ENABLE_POS]) begin
                    state_next.burn = pfl_pkg::BURN_UNLOCKED;
                end else if (trig_wr && reg_wdata == pfl_pkg::BURN_START) begin
                    state_next.burn = pfl_pkg::BURN_ACTIVE;
                    state_next.burn_cnt = BURN_LOAD;
                    // A fresh burn forgets any earlier strap drop
                    state_next.strap_dropped = 1'b0;
                end
            end
            pfl_pkg::BURN_ACTIVE: begin
                // A level 1 burn needs the strap high on every cycle
                if (!state_reg.strap_s2) begin
                    state_next.strap_dropped = 1'b1;
                end
                if (trig_wr && reg_wdata != pfl_pkg::BURN_START) begin
                    state_next.burn = pfl_pkg::BURN_SELECTED;
                end else if (key_wr && reg_wdata != pfl_pkg::UNLOCK_KEY) begin
                    state_next.burn = pfl_pkg::BURN_IDLE;
                end else if (burn_done) begin
                    // One fuse per sequence; back to selected, not re-armed
                    state_next.burn = pfl_pkg::BURN_SELECTED;
                    if (!state_reg.level1_select) begin
                        fuse_next.level0_fuse = 1'b1;
                    end else if (!state_reg.strap_dropped && state_reg.strap_s2) begin
                        fuse_next.level1_fuse = 1'b1;
                    end
                end else begin
                    // Count down; the burn length is the parameter
                    state_next.burn_cnt = state_reg.burn_cnt - 1'b1;
                end
            end
            default: state_next.burn = pfl_pkg::BURN_IDLE;
        endcase

        // Read data, registered; write-only fields read as zero
        state_next.rdata = '0;
        if (fc_rd) begin
            // Other bits of this register belong to the flash controller
            state_next.rdata[pfl_pkg::CODE_PROTECT_POS] = state_reg.code_protect_bit;
        end else if (stat_rd) begin
            // Program enable is write-only and reads back as zero
            state_next.rdata[pfl_pkg::PROGRAM_ENABLE_POS] = 1'b0;
            state_next.rdata[pfl_pkg::STRAP_LEVEL_POS] = state_reg.strap_s2;
            state_next.rdata[pfl_pkg::LEVEL0_FUSE_POS] = fuse_reg.level0_fuse;
            state_next.rdata[pfl_pkg::LEVEL1_FUSE_POS] = fuse_reg.level1_fuse;
        end

        // Request answers, one cycle later; idle cycles answer nothing
        state_next.emu_grant = 1'b0;
        state_next.emu_refuse = 1'b0;
        if (emu_req) begin
            if (emu_ok) begin
                state_next.emu_grant = 1'b1;
            end else begin
                state_next.emu_refuse = 1'b1;
            end
        end
        state_next.cpu_grant = 1'b0;
        state_next.cpu_refuse = 1'b0;
        if (cpu_req) begin
            if (cpu_ok) begin
                state_next.cpu_grant = 1'b1;
            end else begin
                state_next.cpu_refuse = 1'b1;
            end
        end

        // Status levels follow the gate inputs by one cycle
        state_next.emu_disable = emu_off;
        state_next.read_block = protect_on;
        state_next.ram_clear = 1'b0;
        if (emu_req && emu_ok && (emu_op == pfl_pkg::OP_BULK_ERASE)) begin
            // Global erase wipes data RAM even when unprotected
            state_next.ram_clear = 1'b1;
        end

        // Strobe rises with the state, so it covers the whole burn
        state_next.burning = (state_next.burn == pfl_pkg::BURN_ACTIVE);
    end

    // Chip reset clears the lock bit and the sequencer; a reset alone releases level 0 protection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Fuses survive chip reset; only power-on clears the model
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            fuse_reg <= '0;
        end else begin
            // Or-ing in keeps a blown fuse blown whatever fuse_next says
            fuse_reg <= fuse_next | fuse_reg;
        end
    end

    // Register bus
    assign reg_rdata = state_reg.rdata;
    // Request answers
    assign emu_grant = state_reg.emu_grant;
    assign emu_refuse = state_reg.emu_refuse;
    assign emulator_port_disable = state_reg.emu_disable;
    assign cpu_grant = state_reg.cpu_grant;
    assign cpu_refuse = state_reg.cpu_refuse;
    // Protection status
    assign ext_read_block = state_reg.read_block;
    assign external_data_ram_clear = state_reg.ram_clear;
    assign fuse_burn_strobe = state_reg.burning;
endmodule // pfl_lock
`default_nettype wire

// ---- pfl_lock_assertions.sv ----
/*
 * Port-level assertions for the fuse lock: burn timing, request gating and status reads.
 * Assumes one clk domain and the asynchronous active-low rst_n of the lock.
 */
`timescale 1ns/10ps
`default_nettype none
module pfl_lock_assertions #(
    parameter int BURN_CYCLES = pfl_pkg::BURN_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register bus
    input wire logic xsfr_wr,
    input wire logic xsfr_rd,
    input wire logic [15:0] xsfr_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Flash requests
    input wire logic emu_req,
    input wire logic [1:0] emu_op,
    input wire logic emu_grant,
    input wire logic emu_refuse,
    input wire logic cpu_req,
    input wire logic [1:0] cpu_op,
    input wire logic [6:0] cpu_page,
    input wire logic cpu_grant,
    input wire logic cpu_refuse,
    // Protection status
    input wire logic emulator_port_disable,
    input wire logic ext_read_block,
    input wire logic external_data_ram_clear,
    input wire logic fuse_burn_strobe
);
    logic [15:0] run_reg;
    logic [15:0] run_next;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A counter instead of a repetition, since the burn length is a parameter
    assign run_next = fuse_burn_strobe ? run_reg + 16'h0001 : 16'h0000;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) run_reg <= 16'h0000;
        else run_reg <= run_next;
    end
    sequence key_wr;
        xsfr_wr && xsfr_addr == pfl_pkg::ADDR_FUSE_UNLOCK_KEY && reg_wdata == pfl_pkg::UNLOCK_KEY;
    endsequence
    sequence sel_wr;
        xsfr_wr && xsfr_addr == pfl_pkg::ADDR_PROTECTION_FUSE_STATUS && reg_wdata[7];
    endsequence
    sequence go_wr;
        xsfr_wr && xsfr_addr == pfl_pkg::ADDR_FUSE_BURN_TRIGGER && reg_wdata == pfl_pkg::BURN_START;
    endsequence
    sequence stop_wr;
        xsfr_wr && xsfr_addr == pfl_pkg::ADDR_FUSE_BURN_TRIGGER && reg_wdata != pfl_pkg::BURN_START;
    endsequence
    AST_BURN_START: assert property (key_wr ##[1:4] sel_wr ##[1:4] go_wr |=> fuse_burn_strobe)
        else $error("burn did not start after the trigger");
    AST_BURN_LEN: assert property (fuse_burn_strobe |-> run_reg < BURN_CYCLES)
        else $error("burn strobe ran too long");
    AST_BURN_STOP: assert property (fuse_burn_strobe ##0 stop_wr |-> ##[1:2] !fuse_burn_strobe)
        else $error("burn kept running after a stop value");
    AST_L1_REFUSE: assert property (emulator_port_disable && emu_req |=> emu_refuse && !emu_grant)
        else $error("emulator served while disabled");
    AST_L0_EMU: assert property (ext_read_block && emu_req && emu_op != pfl_pkg::OP_BULK_ERASE
        |=> emu_refuse) else $error("emulator op served under protection");
    AST_PAGE0_ERASE: assert property (ext_read_block && cpu_req && cpu_op == pfl_pkg::OP_PAGE_ERASE
        && cpu_page == pfl_pkg::PAGE_ZERO |=> cpu_refuse) else $error("page zero erase served");
    AST_PAGE0_WRITE: assert property (ext_read_block && cpu_req && cpu_op == pfl_pkg::OP_WRITE
        && cpu_page == pfl_pkg::PAGE_ZERO |=> cpu_refuse && !cpu_grant)
        else $error("page zero write served");
    AST_BULK_CLEAR: assert property (emu_req && emu_op == pfl_pkg::OP_BULK_ERASE
        && !emulator_port_disable |=> emu_grant && external_data_ram_clear)
        else $error("bulk erase without data ram clear");
    AST_STATUS_B7: assert property (xsfr_rd && xsfr_addr == pfl_pkg::ADDR_PROTECTION_FUSE_STATUS
        |=> !reg_rdata[7]) else $error("program enable bit read back");
    AST_RESET_CLEAR: assert property ($rose(rst_n) |-> ##1 !ext_read_block)
        else $error("protection survived reset");
endmodule // pfl_lock_assertions
bind pfl_lock pfl_lock_assertions #(.BURN_CYCLES(BURN_CYCLES)) pfl_lock_assertions_i (.*);
`default_nettype wire

// ---- pfl_lock_bench.sv ----
/*
 * Self-checking bench for the fuse lock: registers, fuse burns, protection levels.
 * Assumes the checker is bound in and the flash masters stand for core and emulator.
 */
`timescale 1ns/10ps
`default_nettype none
module pfl_lock_bench;
    localparam int BURN = 20;
    logic clk, rst_n, por_n, sfr_wr, sfr_rd, xsfr_wr, xsfr_rd, strap_pin;
    logic [7:0] sfr_addr, reg_wdata, reg_rdata, ans;
    logic [15:0] xsfr_addr;
    logic emu_req, emu_grant, emu_refuse, emulator_port_disable, cpu_req, cpu_grant, cpu_refuse;
    logic [1:0] emu_op, cpu_op;
    logic [6:0] emu_page, cpu_page;
    logic ext_read_block, external_data_ram_clear, fuse_burn_strobe;
    int errors, checks_done, cycles, n;
    pfl_lock #(.BURN_CYCLES(BURN)) pfl_lock_i (.*);
    pfl_flash_master emu_m (.clk(clk), .req(emu_req), .op(emu_op), .page(emu_page),
        .grant(emu_grant), .refuse(emu_refuse));
    pfl_flash_master cpu_m (.clk(clk), .req(cpu_req), .op(cpu_op), .page(cpu_page),
        .grant(cpu_grant), .refuse(cpu_refuse));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Addresses below 0x100 go on the internal bus, the rest on the external one
    task automatic acc(input logic rd, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a[7:0];
        xsfr_addr = a;
        reg_wdata = d;
        {sfr_rd, sfr_wr} = (a[15:8] == 8'h00) ? {rd, !rd} : 2'b00;
        {xsfr_rd, xsfr_wr} = (a[15:8] != 8'h00) ? {rd, !rd} : 2'b00;
        @(negedge clk);
        ans = reg_rdata;
        {sfr_rd, sfr_wr, xsfr_rd, xsfr_wr} = 4'h0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        acc(1'b0, a, d);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        acc(1'b1, a, 8'h00);
        chk(ans, exp);
    endtask
    task automatic chip_reset;
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
    endtask
    task automatic burn(input logic [7:0] key, input logic [7:0] sel, input logic abort);
        wr(16'hFFD2, key);
        wr(16'hFFD7, sel);
        wr(16'hFFD1, 8'hA6);
        if (abort) wr(16'hFFD1, 8'h00);
        n = 0;
        repeat (BURN + 4) begin
            n += int'(fuse_burn_strobe === 1'b1);
            @(negedge clk);
        end
        wr(16'hFFD1, 8'h00);
        wr(16'hFFD2, 8'h00);
    endtask
    task automatic t_idle;
        rdc(16'h00B2, 8'h00);
        rdc(16'hFFD7, 8'h00);
        rdc(16'hFFD3, 8'h00);
        wr(16'h00B2, 8'h40);
        rdc(16'h00B2, 8'h40);
        chk({7'h00, ext_read_block}, 8'h00);
        emu_m.issue(pfl_pkg::OP_READ, 7'h05, ans);
        chk(ans, 8'h02);
        chip_reset();
        rdc(16'h00B2, 8'h00);
    endtask
    task automatic t_burn0;
        burn(8'h54, 8'h81, 1'b1);
        chk(8'(n), 8'h00);
        burn(8'h55, 8'h81, 1'b0);
        chk(8'(n), 8'h00);
        burn(8'h54, 8'h81, 1'b0);
        chk(8'(n), 8'(BURN));
        rdc(16'hFFD7, 8'h02);
    endtask
    task automatic t_level0;
        wr(16'h00B2, 8'h40);
        @(negedge clk);
        chk({7'h00, ext_read_block}, 8'h01);
        wr(16'h00B2, 8'h00);
        rdc(16'h00B2, 8'h40);
        emu_m.issue(pfl_pkg::OP_READ, 7'h01, ans);
        chk(ans, 8'h01);
        cpu_m.issue(pfl_pkg::OP_WRITE, 7'h00, ans);
        chk(ans, 8'h01);
        cpu_m.issue(pfl_pkg::OP_PAGE_ERASE, 7'h00, ans);
        chk(ans, 8'h01);
        cpu_m.issue(pfl_pkg::OP_WRITE, 7'h01, ans);
        chk(ans, 8'h02);
        emu_m.issue(pfl_pkg::OP_BULK_ERASE, 7'h00, ans);
        chk(ans, 8'h02);
        chk({7'h00, external_data_ram_clear}, 8'h01);
        chip_reset();
        @(negedge clk);
        chk({7'h00, ext_read_block}, 8'h00);
        rdc(16'hFFD7, 8'h02);
        cpu_m.issue(pfl_pkg::OP_WRITE, 7'h00, ans);
        chk(ans, 8'h02);
    endtask
    task automatic t_level1;
        strap_pin = 1'b1;
        repeat (3) @(negedge clk);
        rdc(16'hFFD7, 8'h22);
        burn(8'h54, 8'h82, 1'b0);
        chk(8'(n), 8'(BURN));
        chk({7'h00, emulator_port_disable}, 8'h01);
        emu_m.issue(pfl_pkg::OP_BULK_ERASE, 7'h00, ans);
        chk(ans, 8'h01);
        strap_pin = 1'b0;
        chip_reset();
        repeat (3) @(negedge clk);
        chk({7'h00, emulator_port_disable}, 8'h01);
        rdc(16'hFFD7, 8'h03);
    endtask
    initial begin
        {clk, sfr_wr, sfr_rd, xsfr_wr, xsfr_rd, strap_pin, rst_n, por_n} = 8'h00;
        sfr_addr = 8'h00;
        xsfr_addr = 16'h0000;
        reg_wdata = 8'h00;
        repeat (20) @(negedge clk);
        {rst_n, por_n} = 2'b11;
        t_idle();
        t_burn0();
        t_level0();
        t_level1();
        test_done();
    end
endmodule // pfl_lock_bench
`default_nettype wire

// ---- pfl_pkg.sv ----
/*
 * Constants for the program security fuse lock: register addresses, field
 * positions, key values, burn timing and the fuse burn sequencer states.
 * Assumes a 20 MHz system clock shared with the processor core.
 */
package pfl_pkg;
    localparam logic [7:0] ADDR_FLASH_CONTROL = 8'hB2;
    localparam logic [15:0] ADDR_FUSE_BURN_TRIGGER = 16'hFFD1;
    localparam logic [15:0] ADDR_FUSE_UNLOCK_KEY = 16'hFFD2;
    localparam logic [15:0] ADDR_PROTECTION_FUSE_STATUS = 16'hFFD7;
    localparam int CODE_PROTECT_POS = 6;
    localparam int PROGRAM_ENABLE_POS = 7;
    localparam int STRAP_LEVEL_POS = 5;
    localparam int LEVEL0_FUSE_POS = 1;
    localparam int LEVEL1_FUSE_POS = 0;
    localparam logic [7:0] UNLOCK_KEY = 8'h54;
    localparam logic [7:0] SELECT_LEVEL0 = 8'h81;
    localparam logic [7:0] SELECT_LEVEL1 = 8'h82;
    localparam logic [7:0] BURN_START = 8'hA6;
    localparam logic [7:0] READ_RESET = 8'h00;
    localparam int BURN_TIME_US = 500;
    localparam int CLK_MHZ = 20;
    localparam int BURN_CYCLES = BURN_TIME_US * CLK_MHZ;
    localparam int BURN_CNT_W = 16;
    localparam logic [6:0] PAGE_ZERO = 7'h00;
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_PAGE_ERASE = 2'h2,
        OP_BULK_ERASE = 2'h3
    } pfl_op_t;
    typedef enum logic [1:0] {
        BURN_IDLE = 2'h0,
        BURN_UNLOCKED = 2'h1,
        BURN_SELECTED = 2'h3,
        BURN_ACTIVE = 2'h2
    } pfl_burn_t;
endpackage
